/* File: src/acmp_pkg.sv */
// package: register map, field positions, modes and timing for the comparator event block
package acmp_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ACMP_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACMP_STAT_OFS = 8'h04;
  localparam logic [7:0] ACMP_IRQEN_OFS = 8'h08;
  // control register fields
  localparam int unsigned ACMP_CTRL_EN_BIT = 0;
  localparam int unsigned ACMP_CTRL_IDLE_BIT = 1;
  localparam int unsigned ACMP_CTRL_MODE_LSB = 2;
  localparam int unsigned ACMP_MODE_W = 3;
  // status register fields
  localparam int unsigned ACMP_STAT_FLAG_BIT = 0;
  localparam int unsigned ACMP_STAT_OUT_BIT = 1;
  localparam int unsigned ACMP_STAT_PWR_BIT = 2;
  // interrupt enable register: width and the comparator bit
  localparam int unsigned ACMP_IRQEN_W = 8;
  localparam int unsigned ACMP_IRQEN_CMP_BIT = 6;
  localparam logic [7:0] ACMP_IRQEN_RST = 8'h00;
  // debounce length in sampling clocks
  localparam int unsigned ACMP_DEB_W = 3;
  localparam logic [2:0] ACMP_DEB_CNT = 3'h4;
  localparam logic [2:0] ACMP_DEB_ONE = 3'h1;
  localparam logic [2:0] ACMP_DEB_ZERO = 3'h0;
  // interrupt condition encodings
  typedef enum logic [2:0] {
    ACMP_MODE_LOW = 3'h0,
    ACMP_MODE_RISE = 3'h1,
    ACMP_MODE_TOG_DEB = 3'h2,
    ACMP_MODE_RISE_DEB = 3'h3,
    ACMP_MODE_FALL = 3'h4,
    ACMP_MODE_TOG = 3'h5,
    ACMP_MODE_FALL_DEB = 3'h6,
    ACMP_MODE_NONE = 3'h7
  } acmp_mode_t;
  // debounce filter states, one-hot
  typedef enum logic [1:0] {
    ACMP_DEB_STABLE = 2'h1,
    ACMP_DEB_CHECK = 2'h2
  } acmp_deb_st_t;
endpackage

/* File: src/acmp_evt_if.sv */
// interface: synchronised and debounced comparator samples between internal modules
`timescale 1ns/100ps
`default_nettype none
interface acmp_evt_if;
  logic raw; // synchronised comparator output
  logic deb; // debounced comparator output
  modport src (output raw, output deb);
  modport dst (input raw, input deb);
endinterface
`default_nettype wire

/* File: src/acmp_sync_deb.sv */
// module: two-stage synchroniser and debounce filter for the comparator output
`timescale 1ns/100ps
`default_nettype none
module acmp_sync_deb (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmp_pin,
  acmp_evt_if.src evt
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic deb;
    logic [2:0] cnt;
    acmp_pkg::acmp_deb_st_t st;
  } acmp_deb_s_t;

  acmp_deb_s_t s_ff;
  acmp_deb_s_t nxt_s;

  // a change is accepted only after it held for the full debounce count
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = cmp_pin;
    nxt_s.sync2 = s_ff.sync1;
    case (s_ff.st)
      acmp_pkg::ACMP_DEB_STABLE: begin
        if (s_ff.sync2 != s_ff.deb) begin
          nxt_s.st = acmp_pkg::ACMP_DEB_CHECK;
          nxt_s.cnt = acmp_pkg::ACMP_DEB_ONE;
        end
      end
      acmp_pkg::ACMP_DEB_CHECK: begin
        if (s_ff.sync2 == s_ff.deb) begin
          nxt_s.st = acmp_pkg::ACMP_DEB_STABLE; // glitch, drop it
          nxt_s.cnt = acmp_pkg::ACMP_DEB_ZERO;
        end else if (s_ff.cnt == acmp_pkg::ACMP_DEB_CNT - acmp_pkg::ACMP_DEB_ONE) begin
          nxt_s.deb = s_ff.sync2;
          nxt_s.st = acmp_pkg::ACMP_DEB_STABLE;
          nxt_s.cnt = acmp_pkg::ACMP_DEB_ZERO;
        end else begin
          nxt_s.cnt = s_ff.cnt + acmp_pkg::ACMP_DEB_ONE;
        end
      end
      default: begin
        nxt_s.st = acmp_pkg::ACMP_DEB_STABLE;
        nxt_s.cnt = acmp_pkg::ACMP_DEB_ZERO;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '{sync1: 1'b0, sync2: 1'b0, deb: 1'b0, cnt: 3'h0,
                st: acmp_pkg::ACMP_DEB_STABLE};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign evt.raw = s_ff.sync2;
  assign evt.deb = s_ff.deb;
endmodule
`default_nettype wire

/* File: src/acmp_evt_det.sv */
// module: condition detector selecting level, edge or toggle on the comparator output
`timescale 1ns/100ps
`default_nettype none
module acmp_evt_det (
  input wire logic clk,
  input wire logic arst_n,
  acmp_evt_if.dst evt,
  input wire logic [2:0] mode,
  input wire logic powered,
  output logic hit
);
  typedef struct packed {
    logic prev_raw;
    logic prev_deb;
  } acmp_det_s_t;

  acmp_det_s_t s_ff;
  acmp_det_s_t nxt_s;
  logic raw_g;
  logic deb_g;

  // samples are forced low while the comparator is off
  always_comb begin
    raw_g = evt.raw & powered;
    deb_g = evt.deb & powered;
    nxt_s.prev_raw = raw_g;
    nxt_s.prev_deb = deb_g;
  end

  // condition select per mode
  always_comb begin
    case (acmp_pkg::acmp_mode_t'(mode))
      acmp_pkg::ACMP_MODE_LOW: hit = powered & !raw_g;
      acmp_pkg::ACMP_MODE_RISE: hit = raw_g & !s_ff.prev_raw;
      acmp_pkg::ACMP_MODE_TOG_DEB: hit = deb_g ^ s_ff.prev_deb;
      acmp_pkg::ACMP_MODE_FALL_DEB: hit = !deb_g & s_ff.prev_deb;
      acmp_pkg::ACMP_MODE_RISE_DEB: hit = deb_g & !s_ff.prev_deb;
      acmp_pkg::ACMP_MODE_FALL: hit = !raw_g & s_ff.prev_raw;
      acmp_pkg::ACMP_MODE_TOG: hit = raw_g ^ s_ff.prev_raw;
      default: hit = 1'b0;
    endcase
  end

  // previous sample register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '{prev_raw: 1'b0, prev_deb: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule
`default_nettype wire

/* File: src/acmp_ctrl.sv */
// module: comparator control and event block with apb registers (top)
//
// Functional notes
// - idle run bit set: comparator and event logic keep running in idle.
// - idle run bit clear: comparator is powered down during idle.
// - power-down mode always shuts the comparator down.
// - event flag sets on the selected condition, only while enabled.
// - event flag reaches the interrupt only when enable register bit 6 set.
// - setting the enable bit turns the comparator on.
// - enable clear forces comparator output low and blocks new events.
// - enable set disables digital input buffers of both analog pins.
// - mode 000 sets the flag while the output is low.
// - mode 001 rising, 010 debounced toggle, 110 debounced falling edge.
// - mode 011 debounced rising, 100 falling, 101 plain toggle.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module acmp_ctrl (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CMP_OUT_RAW,
  input wire logic IDLE_MODE,
  input wire logic PDOWN_MODE,
  output logic CMP_POWER_ON,
  output logic CMP_OUT,
  output logic DIN_BUF_DIS_POS,
  output logic DIN_BUF_DIS_NEG,
  output logic CMP_IRQ
);
  typedef struct packed {
    logic en;
    logic idle_run;
    logic [2:0] mode;
    logic [7:0] irq_en;
    logic flag;
    logic pwr;
    logic cmp_out;
    logic irq;
    logic [31:0] prdata;
    logic pslverr;
  } acmp_s_t;

  acmp_s_t s_ff;
  acmp_s_t nxt_s;
  logic hit;
  logic setup;
  logic wr_acc;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_irq_en;
  logic flag_clr;
  logic [31:0] rd_word;

  acmp_evt_if evt ();

  // synchroniser and debounce on the analog comparator output
  acmp_sync_deb acmp_sync_deb_inst (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .cmp_pin(CMP_OUT_RAW),
    .evt(evt.src)
  );

  // condition detector
  acmp_evt_det acmp_evt_det_inst (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .evt(evt.dst),
    .mode(s_ff.mode),
    .powered(s_ff.pwr),
    .hit(hit)
  );

  // apb decode: zero wait states, read data captured in the setup cycle
  always_comb begin
    setup = PSEL & !PENABLE;
    wr_acc = PSEL & PENABLE & PWRITE;
    sel_ctrl = (PADDR == acmp_pkg::ACMP_CTRL_OFS);
    sel_stat = (PADDR == acmp_pkg::ACMP_STAT_OFS);
    sel_irq_en = (PADDR == acmp_pkg::ACMP_IRQEN_OFS);
    flag_clr = wr_acc & sel_stat & PWDATA[acmp_pkg::ACMP_STAT_FLAG_BIT];
  end

  // read mux, unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_word[acmp_pkg::ACMP_CTRL_EN_BIT] = s_ff.en;
      rd_word[acmp_pkg::ACMP_CTRL_IDLE_BIT] = s_ff.idle_run;
      rd_word[acmp_pkg::ACMP_CTRL_MODE_LSB +: acmp_pkg::ACMP_MODE_W] = s_ff.mode;
    end else if (sel_stat) begin
      rd_word[acmp_pkg::ACMP_STAT_FLAG_BIT] = s_ff.flag;
      rd_word[acmp_pkg::ACMP_STAT_OUT_BIT] = s_ff.cmp_out;
      rd_word[acmp_pkg::ACMP_STAT_PWR_BIT] = s_ff.pwr;
    end else if (sel_irq_en) begin
      rd_word[acmp_pkg::ACMP_IRQEN_W-1:0] = s_ff.irq_en;
    end
  end

  // next state: registers, power gating, event flag and interrupt
  always_comb begin
    nxt_s = s_ff;
    if (setup) begin
      nxt_s.prdata = (PWRITE) ? 32'h0000_0000 : rd_word;
      nxt_s.pslverr = !(sel_ctrl | sel_stat | sel_irq_en); // unmapped address
    end
    if (wr_acc & sel_ctrl) begin
      nxt_s.en = PWDATA[acmp_pkg::ACMP_CTRL_EN_BIT];
      nxt_s.idle_run = PWDATA[acmp_pkg::ACMP_CTRL_IDLE_BIT];
      nxt_s.mode = PWDATA[acmp_pkg::ACMP_CTRL_MODE_LSB +: acmp_pkg::ACMP_MODE_W];
    end
    if (wr_acc & sel_irq_en) begin
      nxt_s.irq_en = PWDATA[acmp_pkg::ACMP_IRQEN_W-1:0];
    end
    // power follows enable, idle handling and power-down
    nxt_s.pwr = nxt_s.en & !PDOWN_MODE & (!IDLE_MODE | nxt_s.idle_run);
    // gated comparator output, low whenever disabled or off
    nxt_s.cmp_out = evt.raw & s_ff.pwr & s_ff.en;
    // sticky flag: set wins over a software clear in the same cycle
    if (flag_clr) begin
      nxt_s.flag = 1'b0;
    end
    if (hit & s_ff.en & s_ff.pwr) begin
      nxt_s.flag = 1'b1;
    end
    nxt_s.irq = nxt_s.flag & nxt_s.irq_en[acmp_pkg::ACMP_IRQEN_CMP_BIT];
  end

  // state register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_ff <= '{en: 1'b0, idle_run: 1'b0, mode: 3'h0, irq_en: acmp_pkg::ACMP_IRQEN_RST,
                flag: 1'b0, pwr: 1'b0, cmp_out: 1'b0, irq: 1'b0,
                prdata: 32'h0000_0000, pslverr: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs
  assign PREADY = 1'b1;
  assign PRDATA = s_ff.prdata;
  assign PSLVERR = s_ff.pslverr;
  assign CMP_POWER_ON = s_ff.pwr;
  assign CMP_OUT = s_ff.cmp_out;
  assign DIN_BUF_DIS_POS = s_ff.en;
  assign DIN_BUF_DIS_NEG = s_ff.en;
  assign CMP_IRQ = s_ff.irq;

  // checks on the block's own behaviour
  default clocking acmp_cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  // idle with run bit keeps the comparator powered
  idle_run_on_a: assert property (
    (nxt_s.en & nxt_s.idle_run & IDLE_MODE & !PDOWN_MODE) |=> CMP_POWER_ON)
    else $error("comparator off in idle with run bit set");

  // idle without run bit powers it down
  idle_off_a: assert property (
    (IDLE_MODE & !nxt_s.idle_run) |=> !CMP_POWER_ON)
    else $error("comparator on in idle without run bit");

  // power-down always shuts it down
  pdown_off_a: assert property (
    PDOWN_MODE |=> !CMP_POWER_ON)
    else $error("comparator on in power-down");

  // an enabled, powered hit sets the flag on the next edge
  flag_set_a: assert property (
    (hit & s_ff.en & s_ff.pwr) |=> s_ff.flag)
    else $error("event did not set the flag");

  // the flag stays until software clears it
  flag_sticky_a: assert property (
    (s_ff.flag & !flag_clr) |=> s_ff.flag)
    else $error("event flag cleared without software");

  // interrupt follows flag and enable bit six
  irq_gate_a: assert property (
    CMP_IRQ == (s_ff.flag & s_ff.irq_en[acmp_pkg::ACMP_IRQEN_CMP_BIT]))
    else $error("interrupt does not match flag and enable");

  // writing the enable bit with no low-power mode powers up
  en_on_a: assert property (
    (wr_acc & sel_ctrl & PWDATA[acmp_pkg::ACMP_CTRL_EN_BIT] & !IDLE_MODE & !PDOWN_MODE)
      |=> CMP_POWER_ON)
    else $error("enable write did not power the comparator");

  // disabled comparator reads low and raises no new event
  dis_low_a: assert property (
    !s_ff.en |=> !CMP_OUT)
    else $error("comparator output not forced low");
  dis_no_evt_a: assert property (
    (!s_ff.en & !s_ff.flag) |=> !s_ff.flag)
    else $error("event set while comparator disabled");

  // input buffers disabled whenever enabled
  din_dis_a: assert property (
    (DIN_BUF_DIS_POS == s_ff.en) && (DIN_BUF_DIS_NEG == s_ff.en))
    else $error("input buffer disable does not follow enable");

  // low level mode sets the flag while output is low
  low_level_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_LOW & s_ff.en & s_ff.pwr & !evt.raw) |=> s_ff.flag)
    else $error("low level did not set the flag");

  // plain rising edge mode
  rise_mode_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_RISE & s_ff.en & s_ff.pwr & $past(s_ff.pwr)
      & $rose(evt.raw)) |=> s_ff.flag)
    else $error("rising edge did not set the flag");

  // plain falling edge mode
  fall_mode_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_FALL & s_ff.en & s_ff.pwr & $past(s_ff.pwr)
      & $fell(evt.raw)) |=> s_ff.flag)
    else $error("falling edge did not set the flag");

  // debounced value changes only after four stable samples
  deb_stable_a: assert property (
    $changed(evt.deb) |-> ($past(evt.raw, 1) == evt.deb) && ($past(evt.raw, 2) == evt.deb)
      && ($past(evt.raw, 3) == evt.deb) && ($past(evt.raw, 4) == evt.deb))
    else $error("debounced value changed too early");

  // a software clear with no competing event empties the flag
  flag_clear_a: assert property (
    (flag_clr & !(hit & s_ff.en & s_ff.pwr)) |=> !s_ff.flag)
    else $error("software clear did not empty the flag");

  // an event in the cycle of a clear still sets the flag
  set_wins_a: assert property (
    (flag_clr & hit & s_ff.en & s_ff.pwr) |=> s_ff.flag)
    else $error("clear won over a same-cycle event");

  // the interrupt request stays until software acts
  irq_hold_a: assert property (
    (CMP_IRQ & !flag_clr & !(wr_acc & sel_irq_en)) |=> CMP_IRQ)
    else $error("interrupt request dropped without software");

  // an enabled, powered comparator passes its output through
  out_follow_a: assert property (
    (s_ff.en & s_ff.pwr) |=> (CMP_OUT == $past(evt.raw)))
    else $error("comparator output not passed through");

  // comparator stays off while the enable bit is clear
  off_no_pwr_a: assert property (
    (!s_ff.en & !(wr_acc & sel_ctrl)) |=> !CMP_POWER_ON)
    else $error("comparator powered without enable");

  // debounced toggle mode
  tog_deb_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_TOG_DEB & s_ff.en & s_ff.pwr & $past(s_ff.pwr)
      & $changed(evt.deb)) |=> s_ff.flag)
    else $error("debounced toggle did not set the flag");

  // debounced falling edge mode
  fall_deb_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_FALL_DEB & s_ff.en & s_ff.pwr & $past(s_ff.pwr)
      & $fell(evt.deb)) |=> s_ff.flag)
    else $error("debounced falling edge did not set the flag");

  // debounced rising edge mode
  rise_deb_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_RISE_DEB & s_ff.en & s_ff.pwr & $past(s_ff.pwr)
      & $rose(evt.deb)) |=> s_ff.flag)
    else $error("debounced rising edge did not set the flag");

  // plain toggle mode
  tog_mode_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_TOG & s_ff.en & s_ff.pwr & $past(s_ff.pwr)
      & $changed(evt.raw)) |=> s_ff.flag)
    else $error("toggle did not set the flag");

  // low level mode raises nothing while the output is high
  low_no_evt_a: assert property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_LOW & evt.raw & !s_ff.flag) |=> !s_ff.flag)
    else $error("low level mode set the flag on a high output");

  // an unpowered comparator raises no event
  off_no_evt_a: assert property (
    (!s_ff.pwr & !s_ff.flag) |=> !s_ff.flag)
    else $error("event set while comparator unpowered");

  // power is never on without the enable bit
  pwr_en_a: assert property (
    CMP_POWER_ON |-> s_ff.en)
    else $error("comparator powered while disabled");

  // main scenarios
  flag_tog_deb_c: cover property (
    (s_ff.mode == acmp_pkg::ACMP_MODE_TOG_DEB) & hit & s_ff.en ##1 s_ff.flag);
  flag_clear_c: cover property (s_ff.flag & flag_clr ##1 !s_ff.flag);
  set_clear_c: cover property (flag_clr & hit & s_ff.en & s_ff.pwr);
  idle_run_c: cover property (IDLE_MODE & s_ff.idle_run & CMP_POWER_ON ##1 CMP_IRQ);
  irq_rise_c: cover property (!CMP_IRQ ##1 CMP_IRQ);
endmodule
`default_nettype wire

/* File: tb/acmp_core_model.sv */
// analog comparator core model driving the raw comparator output
`timescale 1ns/100ps
`default_nettype none
module acmp_core_model (
  input wire logic clk,
  input wire logic power_on,
  input wire logic level,
  input wire logic slow,
  output logic cmp_out
);
  logic lag_ff = 1'b0;
  logic junk_ff = 1'b0;
  // slow core answers one cycle late; unpowered core output wanders
  always @(posedge clk) begin
    lag_ff <= level;
    junk_ff <= ~junk_ff;
  end
  // an unpowered core has no defined output, so it changes every cycle
  assign cmp_out = !power_on ? junk_ff : (slow ? lag_ff : level);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the comparator control and event block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, arst_n, psel, penable, pwrite, idle_m, pdown_m, level, slow, raw, err, s, k, e;
  logic pready, pslverr, pwr_on, cmp_out, dis_pos, dis_neg, irq;
  logic [7:0] paddr, irq_en;
  logic [31:0] pwdata, prdata, rd, seed;
  int miscompares, n_compared;

  acmp_ctrl acmp_ctrl_inst (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CMP_OUT_RAW(raw), .IDLE_MODE(idle_m), .PDOWN_MODE(pdown_m),
    .CMP_POWER_ON(pwr_on), .CMP_OUT(cmp_out), .DIN_BUF_DIS_POS(dis_pos),
    .DIN_BUF_DIS_NEG(dis_neg), .CMP_IRQ(irq));
  acmp_core_model acmp_core_model_inst (.clk(clk), .power_on(pwr_on), .level(level),
    .slow(slow), .cmp_out(raw));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic clr_flag();
    apb(1'b1, acmp_pkg::ACMP_STAT_OFS, 32'h1);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // flag expected after a glitch (k=0) or a step (k=1) from start level sl
  function automatic logic exp_flag(input logic [2:0] m, input logic sl, input logic kk);
    case (m)
      3'h0: return 1'b1;
      3'h1: return !(sl && kk);
      3'h2: return kk;
      3'h3: return kk && !sl;
      3'h4: return !(!sl && kk);
      3'h5: return 1'b1;
      3'h6: return kk && sl;
      default: return 1'b0;
    endcase
  endfunction

  // hang guard
  initial begin
    tick(20000);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, idle_m, pdown_m, slow, arst_n} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 1'b1;
    seed = 32'hFA02486D;
    miscompares = 0;
    n_compared = 0;
    tick(8);
    arst_n <= 1'b1;
    tick(1);
    chk({pwr_on, cmp_out, dis_pos, dis_neg, irq}, 5'h00);
    apb(1'b0, acmp_pkg::ACMP_IRQEN_OFS, 32'h0);
    chk(rd, {24'h0, acmp_pkg::ACMP_IRQEN_RST});
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, acmp_pkg::ACMP_CTRL_OFS, 32'h1);
    tick(2);
    chk({pwr_on, dis_pos, dis_neg}, 3'h7);
    // every mode, glitch and step, random start level, speed and enables
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      s = seed[0];
      k = i[3];
      irq_en = seed[15:8];
      slow <= seed[1];
      level <= s;
      apb(1'b1, acmp_pkg::ACMP_IRQEN_OFS, {24'h0, irq_en});
      apb(1'b1, acmp_pkg::ACMP_CTRL_OFS, {seed[31:5], i[2:0], 2'b01});
      apb(1'b0, acmp_pkg::ACMP_CTRL_OFS, 32'h0);
      chk(rd, {27'h0, i[2:0], 2'b01});
      apb(1'b0, acmp_pkg::ACMP_IRQEN_OFS, 32'h0);
      chk({err, rd[30:0]}, {24'h0, irq_en});
      tick(8);
      clr_flag();
      tick(2);
      apb(1'b0, acmp_pkg::ACMP_STAT_OFS, 32'h0);
      chk(rd[2:0], {1'b1, s, i[2:0] == 3'h0 && !s});
      level <= ~s;
      if (!k) begin
        tick(2);
        level <= s;
      end
      tick(12);
      e = exp_flag(i[2:0], s, k);
      apb(1'b0, acmp_pkg::ACMP_STAT_OFS, 32'h0);
      chk(rd[2:0], {1'b1, s ^ k, e});
      chk(irq, e & irq_en[6]);
    end
    // idle without run bit powers the comparator down and blocks events
    slow <= 1'b0;
    apb(1'b1, acmp_pkg::ACMP_CTRL_OFS, {27'h0, acmp_pkg::ACMP_MODE_TOG, 2'b01});
    idle_m <= 1'b1;
    tick(3);
    chk(pwr_on, 1'b0);
    clr_flag();
    tick(10);
    apb(1'b0, acmp_pkg::ACMP_STAT_OFS, 32'h0);
    chk(rd[2:0], 3'h0);
    // idle with run bit keeps the comparator and events alive
    apb(1'b1, acmp_pkg::ACMP_CTRL_OFS, {27'h0, acmp_pkg::ACMP_MODE_TOG, 2'b11});
    tick(8);
    chk(pwr_on, 1'b1);
    clr_flag();
    level <= ~level;
    tick(10);
    apb(1'b0, acmp_pkg::ACMP_STAT_OFS, 32'h0);
    chk(rd[0], 1'b1);
    pdown_m <= 1'b1;
    tick(3);
    chk(pwr_on, 1'b0);
    pdown_m <= 1'b0;
    idle_m <= 1'b0;
    // disabled comparator: output low, low level gives no event
    apb(1'b1, acmp_pkg::ACMP_CTRL_OFS, 32'h0);
    level <= 1'b0;
    tick(8);
    clr_flag();
    tick(8);
    apb(1'b0, acmp_pkg::ACMP_STAT_OFS, 32'h0);
    chk(rd[1:0], 2'h0);
    chk({cmp_out, dis_pos, dis_neg}, 3'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
